// ==== rtl/stc_pkg.sv ====
// constants and types shared by the 16-bit timer and its compare units
package stc_pkg;
  // i/o space addresses
  localparam logic [7:0] STC_ADDR_FLAG    = 8'h16;
  localparam logic [7:0] STC_ADDR_MASK    = 8'h6F;
  localparam logic [7:0] STC_ADDR_CTRL_A  = 8'h80;
  localparam logic [7:0] STC_ADDR_CTRL_B  = 8'h81;
  localparam logic [7:0] STC_ADDR_CTRL_C  = 8'h82;
  localparam logic [7:0] STC_ADDR_CNT_L   = 8'h84;
  localparam logic [7:0] STC_ADDR_CNT_H   = 8'h85;
  localparam logic [7:0] STC_ADDR_CAP_L   = 8'h86;
  localparam logic [7:0] STC_ADDR_CAP_H   = 8'h87;
  localparam logic [7:0] STC_ADDR_CMPA_L  = 8'h88;
  localparam logic [7:0] STC_ADDR_CMPA_H  = 8'h89;
  localparam logic [7:0] STC_ADDR_CMPB_L  = 8'h8A;
  localparam logic [7:0] STC_ADDR_CMPB_H  = 8'h8B;
  localparam logic [7:0] STC_ADDR_BIT_LIM = 8'h20;
  // field positions
  localparam int STC_MODE_A_LSB  = 6;
  localparam int STC_MODE_B_LSB  = 4;
  localparam int STC_WGM_LO_LSB  = 0;
  localparam int STC_CAP_EDGE    = 6;
  localparam int STC_WGM_HI_LSB  = 3;
  localparam int STC_CS_LSB      = 0;
  localparam int STC_FORCE_A     = 7;
  localparam int STC_FORCE_B     = 6;
  localparam int STC_FLAG_OVF    = 0;
  localparam int STC_FLAG_MATCH0 = 1;
  localparam int STC_FLAG_CAP    = 5;
  // reset values and the counter maximum
  localparam logic [7:0]  STC_BYTE_RST = 8'h00;
  localparam logic [15:0] STC_WORD_RST = 16'h0000;
  localparam logic [15:0] STC_MAX      = 16'hFFFF;
  // prescaler masks, one per divider
  localparam int          STC_PSC_W     = 10;
  localparam logic [9:0]  STC_DIV8_M    = 10'h007;
  localparam logic [9:0]  STC_DIV64_M   = 10'h03F;
  localparam logic [9:0]  STC_DIV256_M  = 10'h0FF;
  localparam logic [9:0]  STC_DIV1024_M = 10'h3FF;

  typedef enum logic [2:0] {
    STC_CS_STOP    = 3'b000,
    STC_CS_DIV1    = 3'b001,
    STC_CS_DIV8    = 3'b010,
    STC_CS_DIV64   = 3'b011,
    STC_CS_DIV256  = 3'b100,
    STC_CS_DIV1024 = 3'b101,
    STC_CS_EXT_FALL = 3'b110,
    STC_CS_EXT_RISE = 3'b111
  } stc_clk_sel_t;

  typedef enum logic [3:0] {
    STC_WAVE_NORMAL  = 4'b0000,
    STC_WAVE_CTC_A   = 4'b0100,
    STC_WAVE_PFC_ICR = 4'b1000,
    STC_WAVE_PFC_A   = 4'b1001,
    STC_WAVE_CTC_ICR = 4'b1100
  } stc_wave_t;
endpackage

// ==== rtl/stc_cmp_if.sv ====
// shared counter view from the timer core to its compare units
`timescale 1ns/1ns
interface stc_cmp_if;
  logic        tick;
  logic [15:0] cnt;
  logic [15:0] top;
  logic        down;
  logic        pfc;
  logic        load_now;
  logic        block;
  modport timer (output tick, cnt, top, down, pfc, load_now, block);
  modport unit  (input  tick, cnt, top, down, pfc, load_now, block);
endinterface

// ==== rtl/stc_compare_unit.sv ====
// one double-buffered compare unit with its waveform output
`timescale 1ns/1ns
module stc_compare_unit
  import stc_pkg::*;
(
  // counter view
  stc_cmp_if.unit    cmp,
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register side
  input  wire logic        buf_we,
  input  wire logic [15:0] buf_data,
  input  wire logic [1:0]  out_mode,
  input  wire logic        toggle_ok,
  input  wire logic        force_cmp,
  output      logic [15:0] buffered,
  output      logic [15:0] active,
  // events and pin
  output      logic        match,
  output      logic        compare_out
);
  logic [15:0] next_buffered;
  logic [15:0] next_active;
  logic        next_match;
  logic        next_out;
  logic        hit;
  logic        inv;

  always_comb
  begin
    next_buffered = buf_we ? buf_data : buffered;
    next_active   = cmp.load_now ? buffered : active;
    hit           = cmp.tick && !cmp.block && (cmp.cnt == active);
    next_match    = hit;
    inv           = out_mode[0];
    next_out      = compare_out;
    if (!cmp.pfc)
    begin
      if (hit || force_cmp)
      begin
        unique case (out_mode)
          2'b00: next_out = compare_out;
          2'b01: next_out = ~compare_out;
          2'b10: next_out = 1'b0;
          2'b11: next_out = 1'b1;
        endcase
      end
    end
    else if (out_mode == 2'b01)
    begin
      if (toggle_ok && hit)
        next_out = ~compare_out;
    end
    else if (out_mode[1])
    begin
      if (active == STC_WORD_RST)
        next_out = inv;
      else if (active == cmp.top)
        next_out = ~inv;
      else if (hit)
        next_out = cmp.down ? ~inv : inv;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      buffered    <= STC_WORD_RST;
      active      <= STC_WORD_RST;
      match       <= 1'b0;
      compare_out <= 1'b0;
    end
    else
    begin
      buffered    <= next_buffered;
      active      <= next_active;
      match       <= next_match;
      compare_out <= next_out;
    end
  end
endmodule

// ==== rtl/stc_timer.sv ====
// 16-bit timer with two compare units, capture and byte-wide i/o access
`timescale 1ns/1ns
module stc_timer
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // i/o space access
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_we,
  input  wire logic       io_re,
  input  wire logic       io_bit_op,
  input  wire logic [2:0] io_bit_sel,
  output      logic [7:0] io_rdata,
  // pins
  input  wire logic       ext_count_pin,
  input  wire logic       capture_pin,
  output      logic       compare_out_a,
  output      logic       compare_out_b,
  // gated requests
  output      logic [7:0] irq_pending
);
  stc_cmp_if cmp_bus ();

  logic [7:0]          timer_control_a, timer_control_b, timer_flag_reg, timer_mask_reg;
  logic [7:0]          next_ctrl_a, next_ctrl_b, next_flag, next_mask;
  logic [7:0]          temp, next_temp, next_rdata, next_irq;
  logic [15:0]         timer_count, next_cnt, capture_value, next_cap;
  logic                down, next_down, block, next_block;
  logic [STC_PSC_W-1:0] psc, next_psc;
  logic                ext_s1, ext_s2, ext_s3, cap_s1, cap_s2, cap_s3;
  logic [3:0]          waveform_select;
  logic [15:0]         top_val;
  logic                pfc, tick, cap_edge, icr_top;
  logic [7:0]          set_bits, clr_bits;
  logic [1:0]          buf_we, force_cmp, match, cmp_out, toggle_ok;
  logic [1:0]          out_mode [2];
  logic [15:0]         bufv [2];
  logic [15:0]         active [2];
  logic [15:0]         wr_word;

  function automatic logic div_hit(input logic [STC_PSC_W-1:0] p, input logic [9:0] m);
    div_hit = &(p | ~m);
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

  assign waveform_select = {timer_control_b[STC_WGM_HI_LSB +: 2],
                            timer_control_a[STC_WGM_LO_LSB +: 2]};
  assign pfc      = (waveform_select == STC_WAVE_PFC_ICR) || (waveform_select == STC_WAVE_PFC_A);
  assign icr_top  = (waveform_select == STC_WAVE_PFC_ICR) || (waveform_select == STC_WAVE_CTC_ICR);
  assign wr_word  = {temp, io_wdata};
  assign out_mode[0] = timer_control_a[STC_MODE_A_LSB +: 2];
  assign out_mode[1] = timer_control_a[STC_MODE_B_LSB +: 2];
  assign toggle_ok   = {1'b0, waveform_select == STC_WAVE_PFC_A};

  always_comb
  begin
    unique case (waveform_select)
      STC_WAVE_CTC_A, STC_WAVE_PFC_A:     top_val = active[0];
      STC_WAVE_CTC_ICR, STC_WAVE_PFC_ICR: top_val = capture_value;
      default:                            top_val = STC_MAX;
    endcase
    unique case (stc_clk_sel_t'(timer_control_b[STC_CS_LSB +: 3]))
      STC_CS_STOP:     tick = 1'b0;
      STC_CS_DIV1:     tick = 1'b1;
      STC_CS_DIV8:     tick = div_hit(psc, STC_DIV8_M);
      STC_CS_DIV64:    tick = div_hit(psc, STC_DIV64_M);
      STC_CS_DIV256:   tick = div_hit(psc, STC_DIV256_M);
      STC_CS_DIV1024:  tick = div_hit(psc, STC_DIV1024_M);
      STC_CS_EXT_FALL: tick = ext_s3 & ~ext_s2;
      STC_CS_EXT_RISE: tick = ~ext_s3 & ext_s2;
    endcase
  end

  assign cmp_bus.tick     = tick;
  assign cmp_bus.cnt      = timer_count;
  assign cmp_bus.top      = top_val;
  assign cmp_bus.down     = down;
  assign cmp_bus.pfc      = pfc;
  assign cmp_bus.load_now = !pfc || (tick && timer_count == STC_WORD_RST);
  assign cmp_bus.block    = block;

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_unit
      stc_compare_unit u_cmp (
        .cmp         (cmp_bus),
        .sys_clk     (sys_clk),
        .rst         (rst),
        .buf_we      (buf_we[i]),
        .buf_data    (wr_word),
        .out_mode    (out_mode[i]),
        .toggle_ok   (toggle_ok[i]),
        .force_cmp   (force_cmp[i]),
        .buffered    (bufv[i]),
        .active      (active[i]),
        .match       (match[i]),
        .compare_out (cmp_out[i])
      );
    end
  endgenerate

  always_comb
  begin
    next_ctrl_a = timer_control_a;
    next_ctrl_b = timer_control_b;
    next_mask   = timer_mask_reg;
    next_temp   = temp;
    next_rdata  = io_rdata;
    next_cnt    = timer_count;
    next_cap    = capture_value;
    next_down   = down;
    next_block  = block;
    next_psc    = psc + 1'b1;
    set_bits    = 8'h00;
    clr_bits    = 8'h00;
    buf_we      = 2'b00;
    force_cmp   = 2'b00;
    // counting, on the tick enable only
    if (tick)
    begin
      next_block = 1'b0;
      if (pfc)
      begin
        if (timer_count == STC_WORD_RST)
          set_bits[STC_FLAG_OVF] = 1'b1;
        if (!down)
        begin
          next_down = (timer_count == top_val);
          next_cnt  = next_down ? timer_count - 1'b1 : timer_count + 1'b1;
        end
        else
        begin
          next_down = (timer_count != STC_WORD_RST);
          next_cnt  = next_down ? timer_count - 1'b1 : timer_count + 1'b1;
        end
      end
      else
      begin
        next_down = 1'b0;
        if (timer_count == STC_MAX)
          set_bits[STC_FLAG_OVF] = 1'b1;
        if ((waveform_select == STC_WAVE_CTC_A || waveform_select == STC_WAVE_CTC_ICR)
            && timer_count == top_val)
          next_cnt = STC_WORD_RST;
        else
          next_cnt = timer_count + 1'b1;
      end
    end
    // capture on the chosen pin edge, unless the capture register is top
    cap_edge = timer_control_b[STC_CAP_EDGE] ? (~cap_s3 & cap_s2) : (cap_s3 & ~cap_s2);
    if (cap_edge && !icr_top)
    begin
      next_cap = timer_count;
      set_bits[STC_FLAG_CAP] = 1'b1;
    end
    set_bits[STC_FLAG_MATCH0 +: 2] = match;
    // reads; a low byte read parks the high byte in the latch
    if (io_re)
    begin
      unique case (io_addr)
        STC_ADDR_CTRL_A: next_rdata = timer_control_a;
        STC_ADDR_CTRL_B: next_rdata = timer_control_b;
        STC_ADDR_CTRL_C: next_rdata = 8'h00;
        STC_ADDR_FLAG:   next_rdata = timer_flag_reg;
        STC_ADDR_MASK:   next_rdata = timer_mask_reg;
        STC_ADDR_CNT_L:
        begin
          next_rdata = timer_count[7:0];
          next_temp  = timer_count[15:8];
        end
        STC_ADDR_CAP_L:
        begin
          next_rdata = capture_value[7:0];
          next_temp  = capture_value[15:8];
        end
        STC_ADDR_CMPA_L:
        begin
          next_rdata = bufv[0][7:0];
          next_temp  = bufv[0][15:8];
        end
        STC_ADDR_CMPB_L:
        begin
          next_rdata = bufv[1][7:0];
          next_temp  = bufv[1][15:8];
        end
        STC_ADDR_CNT_H, STC_ADDR_CAP_H, STC_ADDR_CMPA_H, STC_ADDR_CMPB_H:
          next_rdata = temp;
        default:         next_rdata = 8'h00;
      endcase
    end
    // writes; high bytes only load the latch, low bytes commit the pair
    if (io_we)
    begin
      unique case (io_addr)
        STC_ADDR_CTRL_A: next_ctrl_a = io_wdata;
        STC_ADDR_CTRL_B: next_ctrl_b = io_wdata;
        STC_ADDR_CTRL_C:
          force_cmp = {io_wdata[STC_FORCE_B], io_wdata[STC_FORCE_A]};
        STC_ADDR_MASK:   next_mask = io_wdata;
        STC_ADDR_FLAG:
          clr_bits = io_bit_op ? (io_wdata & bit_mask(io_bit_sel)) : io_wdata;
        STC_ADDR_CNT_H, STC_ADDR_CAP_H, STC_ADDR_CMPA_H, STC_ADDR_CMPB_H:
          next_temp = io_wdata;
        STC_ADDR_CNT_L:
        begin
          next_cnt   = wr_word;
          next_block = 1'b1;
        end
        STC_ADDR_CAP_L:  next_cap = wr_word;
        STC_ADDR_CMPA_L: buf_we[0] = 1'b1;
        STC_ADDR_CMPB_L: buf_we[1] = 1'b1;
        default:         next_temp = temp;
      endcase
    end
    // set beats a clear landing in the same cycle
    next_flag = (timer_flag_reg & ~clr_bits) | set_bits;
    next_irq  = timer_flag_reg & timer_mask_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      timer_control_a <= STC_BYTE_RST;
      timer_control_b <= STC_BYTE_RST;
      timer_flag_reg  <= STC_BYTE_RST;
      timer_mask_reg  <= STC_BYTE_RST;
      temp            <= STC_BYTE_RST;
      io_rdata        <= STC_BYTE_RST;
      irq_pending     <= STC_BYTE_RST;
      timer_count     <= STC_WORD_RST;
      capture_value   <= STC_WORD_RST;
      down            <= 1'b0;
      block           <= 1'b0;
      psc             <= '0;
      ext_s1          <= 1'b0;
      ext_s2          <= 1'b0;
      ext_s3          <= 1'b0;
      cap_s1          <= 1'b0;
      cap_s2          <= 1'b0;
      cap_s3          <= 1'b0;
    end
    else
    begin
      timer_control_a <= next_ctrl_a;
      timer_control_b <= next_ctrl_b;
      timer_flag_reg  <= next_flag;
      timer_mask_reg  <= next_mask;
      temp            <= next_temp;
      io_rdata        <= next_rdata;
      irq_pending     <= next_irq;
      timer_count     <= next_cnt;
      capture_value   <= next_cap;
      down            <= next_down;
      block           <= next_block;
      psc             <= next_psc;
      ext_s1          <= ext_count_pin;
      ext_s2          <= ext_s1;
      ext_s3          <= ext_s2;
      cap_s1          <= capture_pin;
      cap_s2          <= cap_s1;
      cap_s3          <= cap_s2;
    end
  end

  assign compare_out_a = cmp_out[0];
  assign compare_out_b = cmp_out[1];
endmodule

// ==== tb/stc_timer_sva.sv ====
// assertions on the 16-bit timer's i/o access and the compare a pin
`timescale 1ns/1ns
module stc_timer_sva
  import stc_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // i/o access
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_we,
  input wire logic       io_re,
  input wire logic       io_bit_op,
  input wire logic [2:0] io_bit_sel,
  input wire logic [7:0] io_rdata,
  // pins and requests
  input wire logic       ext_count_pin,
  input wire logic       capture_pin,
  input wire logic       compare_out_a,
  input wire logic       compare_out_b,
  input wire logic [7:0] irq_pending
);
  logic [7:0] sh_a;
  logic [7:0] sh_b;
  logic [7:0] next_sh_a;
  logic [7:0] next_sh_b;
  logic       plain_wr;
  logic       frozen;

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);

  // shadow of both control bytes, to know mode and clock select
  assign plain_wr = io_we && !io_bit_op;
  assign frozen   = (sh_b[2:0] == 3'h0) && ({sh_b[4:3], sh_a[1:0]} == 4'h0);
  always_comb
  begin
    next_sh_a = (plain_wr && io_addr == STC_ADDR_CTRL_A) ? io_wdata : sh_a;
    next_sh_b = (plain_wr && io_addr == STC_ADDR_CTRL_B) ? io_wdata : sh_b;
  end
  always_ff @(posedge sys_clk)
  begin
    sh_a <= rst ? STC_BYTE_RST : next_sh_a;
    sh_b <= rst ? STC_BYTE_RST : next_sh_b;
  end

  sequence s_wr(logic [7:0] a);
    plain_wr && io_addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    io_re && io_addr == a;
  endsequence

  chk_rdata_hold: assert property (!$past(io_re) |-> $stable(io_rdata))
    else $error("read data moved without a read");
  chk_force_zero: assert property (s_rd(STC_ADDR_CTRL_C) |=> io_rdata == 8'h00)
    else $error("force byte read not zero");
  chk_ctrl_a_back: assert property (s_wr(STC_ADDR_CTRL_A) ##2 s_rd(STC_ADDR_CTRL_A)
    |=> (io_rdata & 8'hF3) == ($past(io_wdata, 3) & 8'hF3))
    else $error("control a readback wrong");
  chk_ctrl_b_back: assert property (s_wr(STC_ADDR_CTRL_B) ##2 s_rd(STC_ADDR_CTRL_B)
    |=> (io_rdata & 8'h5F) == ($past(io_wdata, 3) & 8'h5F))
    else $error("control b readback wrong");
  chk_word_back: assert property (s_wr(STC_ADDR_CMPA_H) ##2 s_wr(STC_ADDR_CMPA_L)
    ##2 s_rd(STC_ADDR_CMPA_L) ##2 s_rd(STC_ADDR_CMPA_H) |=> io_rdata == $past(io_wdata, 7))
    else $error("high byte of word readback wrong");
  chk_mask_off: assert property ((plain_wr && io_addr == STC_ADDR_MASK && io_wdata == 8'h00)
    ##1 !(io_we && io_addr == STC_ADDR_MASK) |=> irq_pending == 8'h00)
    else $error("request passed a cleared mask");
  chk_force_out: assert property (frozen && sh_a[7:6] != 2'b00 && plain_wr
    && io_addr == STC_ADDR_CTRL_C && io_wdata[STC_FORCE_A]
    |=> ##1 compare_out_a == ((sh_a[7:6] == 2'b01) ? !$past(compare_out_a, 2) : sh_a[6]))
    else $error("forced compare a gave wrong level");
  chk_force_quiet: assert property (frozen && plain_wr && io_addr == STC_ADDR_CTRL_C
    && io_wdata[7:6] != 2'b00 && irq_pending == 8'h00 |=> irq_pending == 8'h00 [*3])
    else $error("forced compare raised a request");
endmodule

bind stc_timer stc_timer_sva stc_timer_sva_i (
  .sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
  .io_re(io_re), .io_bit_op(io_bit_op), .io_bit_sel(io_bit_sel), .io_rdata(io_rdata),
  .ext_count_pin(ext_count_pin), .capture_pin(capture_pin), .compare_out_a(compare_out_a),
  .compare_out_b(compare_out_b), .irq_pending(irq_pending)
);

// ==== tb/stc_host_model.sv ====
// host core model driving the timer's byte-wide i/o space
`timescale 1ns/1ns
module stc_host_model
  import stc_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // i/o access
  output      logic [7:0] io_addr,
  output      logic [7:0] io_wdata,
  output      logic       io_we,
  output      logic       io_re,
  output      logic       io_bit_op,
  output      logic [2:0] io_bit_sel
);
  initial
  begin
    io_addr    = 8'h00;
    io_wdata   = 8'h00;
    io_we      = 1'b0;
    io_re      = 1'b0;
    io_bit_op  = 1'b0;
    io_bit_sel = 3'h0;
  end

  // one access: strobe up for one cycle, then an idle cycle
  task automatic acc(input logic we, re, bop, input logic [2:0] sel, input logic [7:0] a, d);
    @(posedge sys_clk);
    io_we      <= we;
    io_re      <= re;
    io_bit_op  <= bop;
    io_bit_sel <= sel;
    io_addr    <= a;
    io_wdata   <= d;
    @(posedge sys_clk);
    io_we      <= 1'b0;
    io_re      <= 1'b0;
    io_bit_op  <= 1'b0;
  endtask

  // high byte first, low commits; nothing may slip in between
  task automatic wr16(input logic [7:0] a_lo, input logic [15:0] v);
    acc(1'b1, 1'b0, 1'b0, 3'h0, a_lo + 8'h01, v[15:8]);
    acc(1'b1, 1'b0, 1'b0, 3'h0, a_lo, v[7:0]);
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the 16-bit timer
`timescale 1ns/1ns
module testbench
  import stc_pkg::*;
;
  typedef struct packed {logic [7:0] d; logic [7:0] m;} stc_exp_t;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ext_count_pin = 1'b0;
  logic       capture_pin = 1'b0;
  logic [7:0] io_addr, io_wdata, io_rdata, irq_pending;
  logic       io_we, io_re, io_bit_op, compare_out_a, compare_out_b;
  logic [2:0] io_bit_sel;
  logic       rd_due = 1'b0;
  stc_exp_t   exp_q[$];
  int         mismatches = 0;
  int         num_checks = 0;
  logic [2:0] cs_tab [3] = '{3'd0, 3'd6, 3'd7};

  always #50 sys_clk = ~sys_clk;

  stc_timer stc_timer_i (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_we(io_we), .io_re(io_re), .io_bit_op(io_bit_op), .io_bit_sel(io_bit_sel),
    .io_rdata(io_rdata), .ext_count_pin(ext_count_pin), .capture_pin(capture_pin),
    .compare_out_a(compare_out_a), .compare_out_b(compare_out_b), .irq_pending(irq_pending));
  stc_host_model stc_host_model_i (.sys_clk(sys_clk), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_we(io_we), .io_re(io_re), .io_bit_op(io_bit_op), .io_bit_sel(io_bit_sel));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, d);
    stc_host_model_i.acc(1'b1, 1'b0, 1'b0, 3'h0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, e, m);
    exp_q.push_back(stc_exp_t'{e, m});
    stc_host_model_i.acc(1'b0, 1'b1, 1'b0, 3'h0, a, 8'h00);
  endtask
  task automatic rd16(input logic [7:0] a_lo, input logic [15:0] v);
    rd(a_lo, v[7:0], 8'hFF);
    rd(a_lo + 8'h01, v[15:8], 8'hFF);
  endtask

  // read data shows one cycle after the taking edge
  always @(posedge sys_clk)
  begin
    if (rd_due)
    begin
      check(io_rdata & exp_q[0].m, exp_q[0].d & exp_q[0].m);
      void'(exp_q.pop_front());
    end
    rd_due <= io_re;
  end

  initial
  begin
    #1_000_000;
    mismatches++;
    finish_test();
  end

  initial
  begin
    logic [7:0]  r;
    logic [15:0] w;
    logic [15:0] cnt;
    int          hi;
    void'($urandom(32'hcc92));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(STC_ADDR_CTRL_A, 8'h00, 8'hFF);
    rd(STC_ADDR_MASK, 8'h00, 8'hFF);
    rd16(STC_ADDR_CNT_L, 16'h0000);
    repeat (4)
    begin
      r = 8'($urandom());
      wr(STC_ADDR_CTRL_A, r);
      rd(STC_ADDR_CTRL_A, r, 8'hF3);
      wr(STC_ADDR_CTRL_B, r & 8'h58);
      rd(STC_ADDR_CTRL_B, r & 8'h58, 8'h5F);
      w = 16'($urandom());
      stc_host_model_i.wr16(STC_ADDR_CMPA_L, w);
      rd16(STC_ADDR_CMPA_L, w);
      stc_host_model_i.wr16(STC_ADDR_CMPB_L, ~w);
      rd16(STC_ADDR_CMPB_L, ~w);
    end
    wr(STC_ADDR_CTRL_A, 8'h00);
    wr(STC_ADDR_CTRL_B, 8'h00);
    wr(STC_ADDR_CTRL_C, 8'hC0);
    rd(STC_ADDR_CTRL_C, 8'h00, 8'hFF);
    // external pin: stopped, falling, rising
    cnt = 16'h0100;
    stc_host_model_i.wr16(STC_ADDR_CNT_L, cnt);
    for (int i = 0; i < 3; i++)
    begin
      wr(STC_ADDR_CTRL_B, {5'h00, cs_tab[i]});
      repeat (5)
      begin
        repeat (4) @(posedge sys_clk);
        ext_count_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext_count_pin <= 1'b0;
      end
      repeat (6) @(posedge sys_clk);
      wr(STC_ADDR_CTRL_B, 8'h00);
      cnt = cnt + ((i == 0) ? 16'h0000 : 16'h0005);
      rd16(STC_ADDR_CNT_L, cnt);
    end
    // capture of a stopped counter on a rising pin edge
    stc_host_model_i.wr16(STC_ADDR_CNT_L, w);
    wr(STC_ADDR_CTRL_B, 8'h40);
    capture_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    capture_pin <= 1'b0;
    rd16(STC_ADDR_CAP_L, w);
    rd(STC_ADDR_FLAG, 8'h20, 8'h20);
    // divide by eight: eighty cycles give ten ticks whatever the phase
    stc_host_model_i.wr16(STC_ADDR_CNT_L, 16'h0000);
    wr(STC_ADDR_CTRL_B, 8'h02);
    repeat (78) @(posedge sys_clk);
    wr(STC_ADDR_CTRL_B, 8'h00);
    rd16(STC_ADDR_CNT_L, 16'h000A);
    // both matches, then a single-bit clear
    wr(STC_ADDR_FLAG, 8'hFF);
    stc_host_model_i.wr16(STC_ADDR_CNT_L, 16'h0000);
    stc_host_model_i.wr16(STC_ADDR_CMPA_L, 16'h000A);
    stc_host_model_i.wr16(STC_ADDR_CMPB_L, 16'h0005);
    wr(STC_ADDR_MASK, 8'h27);
    wr(STC_ADDR_CTRL_B, 8'h01);
    for (int k = 0; k < 100 && irq_pending[2:1] !== 2'b11; k++)
      @(posedge sys_clk);
    wr(STC_ADDR_CTRL_B, 8'h00);
    check(irq_pending, 8'h06);
    stc_host_model_i.acc(1'b1, 1'b0, 1'b1, 3'h1, STC_ADDR_FLAG, 8'hFF);
    rd(STC_ADDR_FLAG, 8'h04, 8'h27);
    wr(STC_ADDR_MASK, 8'h00);
    repeat (2) @(posedge sys_clk);
    check(irq_pending, 8'h00);
    // counter rewritten onto both compare values while running
    wr(STC_ADDR_FLAG, 8'hFF);
    stc_host_model_i.wr16(STC_ADDR_CNT_L, 16'h0100);
    stc_host_model_i.wr16(STC_ADDR_CMPA_L, 16'h0005);
    wr(STC_ADDR_CTRL_B, 8'h01);
    stc_host_model_i.wr16(STC_ADDR_CNT_L, 16'h0005);
    repeat (20) @(posedge sys_clk);
    wr(STC_ADDR_CTRL_B, 8'h00);
    rd(STC_ADDR_FLAG, 8'h00, 8'h06);
    // forced compares in clear, set and toggle modes
    wr(STC_ADDR_FLAG, 8'hFF);
    wr(STC_ADDR_MASK, 8'h27);
    for (int m = 2; m < 5; m++)
    begin
      r = {2'(m), 2'(m), 4'h0} | ((m == 4) ? 8'h50 : 8'h00);
      wr(STC_ADDR_CTRL_A, r);
      wr(STC_ADDR_CTRL_C, 8'hC0);
      repeat (2) @(posedge sys_clk);
      check({7'h00, compare_out_a}, {7'h00, m == 3});
      check({7'h00, compare_out_b}, {7'h00, m == 3});
      check(irq_pending, 8'h00);
    end
    // waveform nine, top 16: a toggles, b at the extremes
    // start below top from bottom, never through waveform eight
    wr(STC_ADDR_CTRL_A, 8'h61);
    stc_host_model_i.wr16(STC_ADDR_CNT_L, 16'h0000);
    stc_host_model_i.wr16(STC_ADDR_CMPA_L, 16'h0010);
    wr(STC_ADDR_CTRL_B, 8'h11);
    for (int i = 0; i < 4; i++)
    begin
      stc_host_model_i.wr16(STC_ADDR_CMPB_L, i[0] ? 16'h0010 : 16'h0000);
      wr(STC_ADDR_CTRL_A, {2'b01, i[1] ? 2'b11 : 2'b10, 4'h1});
      repeat (70) @(posedge sys_clk);
      hi = 0;
      for (int k = 0; k < 64; k++)
      begin
        @(posedge sys_clk);
        hi = hi + compare_out_a;
        check({7'h00, compare_out_b}, {7'h00, i[0] ^ i[1]});
      end
      check(8'(hi), 8'd32);
    end
    wr(STC_ADDR_CTRL_B, 8'h00);
    wr(STC_ADDR_CTRL_A, 8'h00);
    repeat (4) @(posedge sys_clk);
    finish_test();
  end
endmodule
